// ### hw/ncq_host.sv
// Host-side sequencer driving a multiplexed 8-bit NAND flash over its pins.
// Assumes flash pins are synchronous to clk (25 MHz) and ready_busy is pulled up externally.
module ncq_host
	import ncq_pkg::*;
#(
	parameter int unsigned XFER_MAX = ncq_pkg::PAGE_BYTES
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    ce,
	// Operation request
	input  wire logic                    op_valid,
	output logic                         op_ready,
	input  wire ncq_pkg::ncq_op_t        op_code,
	input  wire logic [ncq_pkg::COL_W-1:0]  op_col,
	input  wire logic [ncq_pkg::PAGE_W-1:0] op_page,
	input  wire logic [ncq_pkg::BLK_W-1:0]  op_block,
	input  wire logic [11:0]             op_len,
	output logic                         op_done,
	output logic                         op_rejected,
	// Write data stream
	input  wire logic                    wr_valid,
	output logic                         wr_ready,
	input  wire logic [7:0]              wr_data,
	// Read data stream
	output logic                         rd_valid,
	input  wire logic                    rd_ready,
	output logic [7:0]                   rd_data,
	// Flash pins
	output logic                         chip_sel_n,
	output logic                         cmd_latch,
	output logic                         addr_latch,
	output logic                         write_strobe_n,
	output logic                         read_strobe_n,
	output logic                         write_prot_n,
	output logic [7:0]                   byte_port_o,
	output logic                         byte_port_oe,
	input  wire logic [7:0]              byte_port_i,
	input  wire logic                    ready_busy
);
	import ncq_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_CMD1,
		ST_ADDR,
		ST_ADL,
		ST_WDATA,
		ST_CMD2,
		ST_ADDR2,
		ST_WB,
		ST_BUSY,
		ST_RDATA,
		ST_DONE
	} ncq_state_t;

	localparam logic [CNT_W-1:0] WP_LEN  = CNT_W'(CYC_WP - 1);
	localparam logic [CNT_W-1:0] WH_LEN  = CNT_W'(CYC_WH - 1);
	localparam logic [CNT_W-1:0] REA_LEN = CNT_W'(CYC_REA - 1);
	localparam logic [CNT_W-1:0] ADL_LEN = CNT_W'(CYC_ADL - 1);
	localparam logic [CNT_W-1:0] WB_LEN  = CNT_W'(CYC_WB - 1);

	if (XFER_MAX < 1 || XFER_MAX > 4095) begin : g_bad_xfer
		$error("ncq_host: XFER_MAX must fit the 12-bit length");
	end
	if (CYC_WP < 1 || CYC_WH < 1 || CYC_REA < 1 || CYC_ADL > 2**CNT_W
			|| CYC_WB > 2**CNT_W || CYC_REA > 2**CNT_W) begin : g_bad_cyc
		$error("ncq_host: strobe timing does not fit the timer");
	end

	ncq_state_t        state_q;
	ncq_state_t        after_cmd2;
	ncq_state_t        after_data;
	ncq_state_t        after_addr;
	// Plan of the accepted operation
	logic [7:0]        cmd1_q;
	logic [7:0]        cmd2_q;
	logic              has2_q;
	logic              post_q;
	logic              wait_q;
	logic              rd_q;
	logic              wr_q;
	logic [2:0]        naddr_q;
	logic [1:0]        aidx_q;
	logic [7:0]        abyte_q [4];
	logic [11:0]       cnt_q;
	// Strobe engine
	logic              wlow_q;
	logic              whigh_q;
	logic              rlow_q;
	logic              rhigh_q;
	logic [CNT_W-1:0]  tmr_q;
	logic [CNT_W-1:0]  wt_q;
	logic              bus_idle;
	logic              step_done;
	// Read path into the buffer
	logic              push_q;
	logic [7:0]        push_data_q;
	logic              skid_ready;
	// Registered outputs
	logic              op_ready_q;
	logic              op_done_q;
	logic              op_rejected_q;
	logic              wr_ready_q;
	logic              cs_n_q;
	logic              cl_q;
	logic              al_q;
	logic              we_n_q;
	logic              re_n_q;
	logic              wp_n_q;
	logic [7:0]        dout_q;
	logic              oe_q;
	// Plan decode of the offered operation
	logic [7:0]        p_cmd1;
	logic [7:0]        p_cmd2;
	logic              p_has2;
	logic              p_post;
	logic              p_wait;
	logic              p_rd;
	logic              p_wr;
	logic [2:0]        p_naddr;
	logic [7:0]        p_ab [4];
	logic [11:0]       p_len;
	logic              p_allowed;
	logic [7:0]        col_lo;
	logic [7:0]        col_hi;
	logic [7:0]        row_lo;
	logic [7:0]        row_hi;

	assign op_ready       = op_ready_q;
	assign op_done        = op_done_q;
	assign op_rejected    = op_rejected_q;
	assign wr_ready       = wr_ready_q;
	assign chip_sel_n     = cs_n_q;
	assign cmd_latch      = cl_q;
	assign addr_latch     = al_q;
	assign write_strobe_n = we_n_q;
	assign read_strobe_n  = re_n_q;
	assign write_prot_n   = wp_n_q;
	assign byte_port_o    = dout_q;
	assign byte_port_oe   = oe_q;

	assign col_lo = op_col[7:0];
	assign col_hi = {4'h0, op_col[11:8]};
	assign row_lo = {op_block[1:0], op_page};
	assign row_hi = op_block[9:2];

	assign p_len = (op_code == NCQ_OP_STATUS) ? 12'h001
		: ((op_len > 12'(XFER_MAX)) ? 12'(XFER_MAX) : op_len);
	// Busy device takes only reset or status
	assign p_allowed = ready_busy || op_code == NCQ_OP_RESET
		|| op_code == NCQ_OP_STATUS;

	always_comb begin
		p_cmd1  = CMD_RESET;
		p_cmd2  = CMD_READ_GO;
		p_has2  = 1'b0;
		p_post  = 1'b0;
		p_wait  = 1'b0;
		p_rd    = 1'b0;
		p_wr    = 1'b0;
		p_naddr = NADDR_NONE;
		p_ab[0] = col_lo;
		p_ab[1] = col_hi;
		p_ab[2] = row_lo;
		p_ab[3] = row_hi;
		case (op_code)
			NCQ_OP_RESET: begin
				p_wait = 1'b1;
			end
			NCQ_OP_STATUS: begin
				p_cmd1 = CMD_STATUS;
				p_rd   = 1'b1;
			end
			NCQ_OP_ID: begin
				p_cmd1  = CMD_ID;
				p_naddr = NADDR_ONE;
				p_ab[0] = 8'h00;
				p_rd    = 1'b1;
			end
			NCQ_OP_READ, NCQ_OP_READ_CB: begin
				p_cmd1  = CMD_READ;
				p_naddr = NADDR_FULL;
				p_has2  = 1'b1;
				p_cmd2  = (op_code == NCQ_OP_READ) ? CMD_READ_GO : CMD_CB_GO;
				p_wait  = 1'b1;
				p_rd    = (op_code == NCQ_OP_READ);
			end
			NCQ_OP_PROG, NCQ_OP_PROG_CACHE: begin
				p_cmd1  = CMD_PROG;
				p_naddr = NADDR_FULL;
				p_wr    = 1'b1;
				p_has2  = 1'b1;
				p_cmd2  = (op_code == NCQ_OP_PROG) ? CMD_PROG_GO : CMD_CACHE_GO;
				p_wait  = 1'b1;
			end
			NCQ_OP_CB_PROG: begin
				p_cmd1  = CMD_CB_PROG;
				p_naddr = NADDR_FULL;
				p_has2  = 1'b1;
				p_cmd2  = CMD_PROG_GO;
				p_wait  = 1'b1;
			end
			NCQ_OP_ERASE: begin
				p_cmd1  = CMD_ERASE;
				p_naddr = NADDR_ROW;
				p_ab[0] = row_lo;
				p_ab[1] = row_hi;
				p_has2  = 1'b1;
				p_cmd2  = CMD_ERASE_GO;
				p_wait  = 1'b1;
			end
			NCQ_OP_RND_IN: begin
				p_cmd1  = CMD_CB_PROG;
				p_naddr = NADDR_COL;
				p_wr    = 1'b1;
			end
			NCQ_OP_RND_OUT: begin
				p_cmd1  = CMD_RND_OUT;
				p_naddr = NADDR_COL;
				p_has2  = 1'b1;
				p_cmd2  = CMD_RND_OUT_GO;
				p_rd    = 1'b1;
			end
			NCQ_OP_CACHE_NEXT, NCQ_OP_CACHE_LAST: begin
				p_cmd1 = (op_code == NCQ_OP_CACHE_NEXT) ? CMD_CACHE_RD : CMD_CACHE_END;
				p_wait = 1'b1;
				p_rd   = 1'b1;
			end
			NCQ_OP_UNLOCK: begin
				p_cmd1  = CMD_UNLK_LO;
				p_naddr = NADDR_ROW;
				p_ab[0] = row_lo;
				p_ab[1] = row_hi;
				p_has2  = 1'b1;
				p_cmd2  = CMD_UNLK_HI;
				p_post  = 1'b1;
			end
			NCQ_OP_LOCK: begin
				p_cmd1 = CMD_LOCK;
			end
			NCQ_OP_LOCK_TIGHT: begin
				p_cmd1 = CMD_LOCK_TIGHT;
			end
			default: begin
				p_cmd1 = CMD_RESET;
			end
		endcase
	end

	always_comb begin
		if (post_q) begin
			after_cmd2 = ST_ADDR2;
		end else if (wait_q) begin
			after_cmd2 = ST_WB;
		end else if (rd_q && cnt_q != 12'h000) begin
			after_cmd2 = ST_RDATA;
		end else begin
			after_cmd2 = ST_DONE;
		end
		after_data = has2_q ? ST_CMD2 : after_cmd2;
		after_addr = (wr_q && cnt_q != 12'h000) ? ST_ADL : after_data;
	end

	assign bus_idle  = !(wlow_q || whigh_q || rlow_q || rhigh_q);
	assign step_done = (whigh_q || rhigh_q) && tmr_q == '0;

	// Strobe phases
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q       <= ST_IDLE;
			cmd1_q        <= 8'h00;
			cmd2_q        <= 8'h00;
			has2_q        <= 1'b0;
			post_q        <= 1'b0;
			wait_q        <= 1'b0;
			rd_q          <= 1'b0;
			wr_q          <= 1'b0;
			naddr_q       <= 3'h0;
			aidx_q        <= 2'h0;
			abyte_q       <= '{default: 8'h00};
			cnt_q         <= 12'h000;
			wlow_q        <= 1'b0;
			whigh_q       <= 1'b0;
			rlow_q        <= 1'b0;
			rhigh_q       <= 1'b0;
			tmr_q         <= '0;
			wt_q          <= '0;
			push_q        <= 1'b0;
			push_data_q   <= 8'h00;
			op_ready_q    <= 1'b0;
			op_done_q     <= 1'b0;
			op_rejected_q <= 1'b0;
			wr_ready_q    <= 1'b0;
			cs_n_q        <= 1'b1;
			cl_q          <= 1'b0;
			al_q          <= 1'b0;
			we_n_q        <= 1'b1;
			re_n_q        <= 1'b1;
			wp_n_q        <= 1'b0;
			dout_q        <= 8'h00;
			oe_q          <= 1'b0;
		end else if (ce) begin
			wp_n_q        <= 1'b1;
			op_done_q     <= 1'b0;
			op_rejected_q <= 1'b0;
			push_q        <= 1'b0;
			if (wlow_q) begin
				if (tmr_q == '0) begin
					// Byte, latches and select stay put across this rise
					we_n_q  <= 1'b1;
					wlow_q  <= 1'b0;
					whigh_q <= 1'b1;
					tmr_q   <= WH_LEN;
				end else begin
					tmr_q <= tmr_q - CNT_W'(1);
				end
			end
			if (rlow_q) begin
				if (tmr_q == '0) begin
					re_n_q      <= 1'b1;
					rlow_q      <= 1'b0;
					rhigh_q     <= 1'b1;
					tmr_q       <= WH_LEN;
					push_q      <= 1'b1;
					push_data_q <= byte_port_i;
				end else begin
					tmr_q <= tmr_q - CNT_W'(1);
				end
			end
			if (step_done) begin
				whigh_q <= 1'b0;
				rhigh_q <= 1'b0;
			end else if (whigh_q || rhigh_q) begin
				tmr_q <= tmr_q - CNT_W'(1);
			end
			case (state_q)
				ST_IDLE: begin
					op_ready_q <= 1'b1;
					if (op_valid && op_ready_q) begin
						op_ready_q <= 1'b0;
						if (!p_allowed) begin
							op_rejected_q <= 1'b1;
						end else begin
							cmd1_q  <= p_cmd1;
							cmd2_q  <= p_cmd2;
							has2_q  <= p_has2;
							post_q  <= p_post;
							wait_q  <= p_wait;
							rd_q    <= p_rd;
							wr_q    <= p_wr;
							naddr_q <= p_naddr;
							abyte_q <= p_ab;
							cnt_q   <= p_len;
							cs_n_q  <= 1'b0;
							state_q <= ST_CMD1;
						end
					end
				end
				ST_CMD1, ST_CMD2: begin
					if (bus_idle) begin
						cl_q   <= 1'b1;
						al_q   <= 1'b0;
						dout_q <= (state_q == ST_CMD1) ? cmd1_q : cmd2_q;
						oe_q   <= 1'b1;
						we_n_q <= 1'b0;
						wlow_q <= 1'b1;
						tmr_q  <= WP_LEN;
					end
					if (step_done) begin
						aidx_q <= 2'h0;
						if (state_q == ST_CMD2) begin
							state_q <= after_cmd2;
						end else if (naddr_q != NADDR_NONE) begin
							state_q <= ST_ADDR;
						end else begin
							state_q <= after_addr;
						end
					end
				end
				ST_ADDR, ST_ADDR2: begin
					if (bus_idle) begin
						cl_q   <= 1'b0;
						al_q   <= 1'b1;
						dout_q <= abyte_q[aidx_q];
						oe_q   <= 1'b1;
						we_n_q <= 1'b0;
						wlow_q <= 1'b1;
						tmr_q  <= WP_LEN;
					end
					if (step_done) begin
						aidx_q <= aidx_q + 2'h1;
						// Stop at the count the operation needs
						if ({1'b0, aidx_q} == naddr_q - 3'h1) begin
							state_q <= (state_q == ST_ADDR) ? after_addr : ST_DONE;
						end
					end
				end
				ST_ADL: begin
					if (wt_q == ADL_LEN) begin
						wt_q    <= '0;
						state_q <= ST_WDATA;
					end else begin
						wt_q <= wt_q + CNT_W'(1);
					end
				end
				ST_WDATA: begin
					if (bus_idle) begin
						if (wr_ready_q && wr_valid) begin
							wr_ready_q <= 1'b0;
							cl_q       <= 1'b0;
							al_q       <= 1'b0;
							dout_q     <= wr_data;
							oe_q       <= 1'b1;
							we_n_q     <= 1'b0;
							wlow_q     <= 1'b1;
							tmr_q      <= WP_LEN;
						end else begin
							wr_ready_q <= 1'b1;
						end
					end
					if (step_done) begin
						cnt_q <= cnt_q - 12'h001;
						if (cnt_q == 12'h001) begin
							state_q <= after_data;
						end
					end
				end
				ST_WB: begin
					// Busy flag is not valid until this gap has passed
					if (wt_q == WB_LEN) begin
						wt_q    <= '0;
						state_q <= ST_BUSY;
					end else begin
						wt_q <= wt_q + CNT_W'(1);
					end
				end
				ST_BUSY: begin
					if (ready_busy) begin
						state_q <= (rd_q && cnt_q != 12'h000) ? ST_RDATA : ST_DONE;
					end
				end
				ST_RDATA: begin
					// Start a read only with room, so a stall loses no byte
					if (bus_idle && skid_ready && !push_q) begin
						cl_q   <= 1'b0;
						al_q   <= 1'b0;
						oe_q   <= 1'b0;
						re_n_q <= 1'b0;
						rlow_q <= 1'b1;
						tmr_q  <= REA_LEN;
					end
					if (step_done) begin
						cnt_q <= cnt_q - 12'h001;
						if (cnt_q == 12'h001) begin
							state_q <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					cs_n_q    <= 1'b1;
					cl_q      <= 1'b0;
					al_q      <= 1'b0;
					oe_q      <= 1'b0;
					op_done_q <= 1'b1;
					state_q   <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	ncq_skid #(
		.W(8)
	) u_skid (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.in_valid  (push_q),
		.in_ready  (skid_ready),
		.in_data   (push_data_q),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);
endmodule : ncq_host

// ### hw/ncq_pkg.sv
// Constants shared by the NAND host-side sequencer and its testbench.
// Assumes a 25 MHz single clock domain; the flash pins are sampled synchronously.
package ncq_pkg;
	localparam int unsigned CLK_MHZ       = 25;
	// Strobe phase lengths in ns, rounded up to whole cycles, with one cycle more for CYC_REA
	localparam int unsigned T_WP_NS       = 12;
	localparam int unsigned T_WH_NS       = 10;
	localparam int unsigned T_WB_NS       = 100;
	localparam int unsigned T_ADL_NS      = 100;
	localparam int unsigned T_RP_NS       = 12;
	localparam int unsigned T_REA_NS      = 20;
	localparam int unsigned CYC_WP        = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CYC_WH        = (T_WH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CYC_WB        = (T_WB_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CYC_ADL       = (T_ADL_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CYC_REA       = (T_REA_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int unsigned CNT_W         = 4;
	// Page and array geometry
	localparam int unsigned PAGE_BYTES    = 2112;
	localparam int unsigned SPARE_START   = 2048;
	localparam int unsigned BLOCKS        = 1024;
	localparam int unsigned COL_W         = 12;
	localparam int unsigned PAGE_W        = 6;
	localparam int unsigned BLK_W         = 10;
	// Command codes
	localparam logic [7:0] CMD_READ       = 8'h00;
	localparam logic [7:0] CMD_READ_GO    = 8'h30;
	localparam logic [7:0] CMD_CB_GO      = 8'h35;
	localparam logic [7:0] CMD_ID         = 8'h90;
	localparam logic [7:0] CMD_RESET      = 8'hFF;
	localparam logic [7:0] CMD_UNLK_LO    = 8'h23;
	localparam logic [7:0] CMD_UNLK_HI    = 8'h24;
	localparam logic [7:0] CMD_LOCK       = 8'h2A;
	localparam logic [7:0] CMD_LOCK_TIGHT = 8'h2C;
	localparam logic [7:0] CMD_LOCK_STAT  = 8'h7A;
	localparam logic [7:0] CMD_PROG       = 8'h80;
	localparam logic [7:0] CMD_PROG_GO    = 8'h10;
	localparam logic [7:0] CMD_CACHE_GO   = 8'h15;
	localparam logic [7:0] CMD_CB_PROG    = 8'h85;
	localparam logic [7:0] CMD_ERASE      = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO   = 8'hD0;
	localparam logic [7:0] CMD_RND_OUT    = 8'h05;
	localparam logic [7:0] CMD_RND_OUT_GO = 8'hE0;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_CACHE_RD   = 8'h31;
	localparam logic [7:0] CMD_CACHE_END  = 8'h3F;
	// Address cycle counts per operation shape
	localparam logic [2:0] NADDR_NONE     = 3'd0;
	localparam logic [2:0] NADDR_ONE      = 3'd1;
	localparam logic [2:0] NADDR_COL      = 3'd2;
	localparam logic [2:0] NADDR_ROW      = 3'd2;
	localparam logic [2:0] NADDR_FULL     = 3'd4;
	// Operation requests from the user side
	typedef enum logic [3:0] {
		NCQ_OP_RESET, NCQ_OP_STATUS, NCQ_OP_ID, NCQ_OP_READ, NCQ_OP_READ_CB,
		NCQ_OP_PROG, NCQ_OP_PROG_CACHE, NCQ_OP_CB_PROG, NCQ_OP_ERASE,
		NCQ_OP_RND_IN, NCQ_OP_RND_OUT, NCQ_OP_CACHE_NEXT, NCQ_OP_CACHE_LAST,
		NCQ_OP_UNLOCK, NCQ_OP_LOCK, NCQ_OP_LOCK_TIGHT
	} ncq_op_t;
	localparam ncq_op_t NCQ_OP_LOCK_STAT_ALIAS = NCQ_OP_LOCK;
endpackage : ncq_pkg

// ### hw/ncq_skid.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; ce freezes all state.
module ncq_skid #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem_q [2];
	logic         wp_q;
	logic         rp_q;
	logic [1:0]   cnt_q;
	logic         push;
	logic         pop;

	initial begin
		if (W < 1) $error("ncq_skid: W must be positive");
	end

	assign in_ready  = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);
	assign out_data  = mem_q[rp_q];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'd0;
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= in_data;
				wp_q        <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : ncq_skid

// ### verif/ncq_flash_model.sv
// Flash model: latches address cycles, goes busy after confirms.
module ncq_flash_model(input wire logic clk, cs_n, cl, al, we_n, re_n,
	input wire logic [7:0] d, output logic rb, output logic [7:0] q);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] a [4];
	logic       we_q = 1'b1, re_q = 1'b1;
	logic [7:0] p = 8'h00;
	int         n = 0, bc = 0, dn = 0;
	wire        wr = we_n && !we_q && !cs_n;
	initial rb = 1'b1;
	// Released port shows the inverse so stale bytes never look valid
	assign q = re_n ? ~p : p;
	always @(posedge clk) begin
		we_q <= we_n;
		re_q <= re_n;
		if (bc > 0) bc <= bc - 1;
		else rb <= 1'b1;
		if (wr && cl) n <= 0;
		if (wr && cl && d == 8'h80) dn <= 0;
		else if (wr && !cl && !al) dn <= dn + 1;
		if (wr && cl && d inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'h31, 8'h3F}) begin
			rb <= 1'b0;
			bc <= 20;
		end
		if (wr && al && n < 4) begin
			a[n] <= d;
			n <= n + 1;
		end
		if (wr && cl) p <= 8'h00;
		else if (!re_n && re_q) p <= p + 8'h01;
	end
endmodule : ncq_flash_model

// ### verif/ncq_host_sva.sv
// Pin checker for ncq_host.
// Assumes flash pins are sampled on clk.
module ncq_host_sva(input wire logic clk, resetn, chip_sel_n, cmd_latch, addr_latch,
	write_strobe_n, read_strobe_n, write_prot_n, byte_port_oe, ready_busy,
	input wire logic [7:0] byte_port_o);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_cmd; !write_strobe_n && cmd_latch; endsequence
	property p_lat; !write_strobe_n |-> !(cmd_latch && addr_latch); endproperty
	a_lat: assert property (p_lat) else $error("both latches high");
	property p_cs; !write_strobe_n |-> !chip_sel_n; endproperty
	a_cs: assert property (p_cs) else $error("write while deselected");
	property p_rcs; !read_strobe_n |-> !chip_sel_n; endproperty
	a_rcs: assert property (p_rcs) else $error("read while deselected");
	property p_oe; !write_strobe_n |-> byte_port_oe; endproperty
	a_oe: assert property (p_oe) else $error("port undriven on write");
	property p_roe; !read_strobe_n |-> !byte_port_oe && write_strobe_n; endproperty
	a_roe: assert property (p_roe) else $error("port clash on read");
	property p_hold; !write_strobe_n ##1 !write_strobe_n |-> $stable(byte_port_o); endproperty
	a_hold: assert property (p_hold) else $error("byte moved in strobe");
	property p_busy; s_cmd ##0 !ready_busy |-> byte_port_o inside {8'hFF, 8'h70, 8'h7A}; endproperty
	a_busy: assert property (p_busy) else $error("command while busy");
	property p_wp; s_cmd ##0 byte_port_o inside {8'h80, 8'h60} |-> write_prot_n; endproperty
	a_wp: assert property (p_wp) else $error("write with protect low");
endmodule : ncq_host_sva
bind ncq_host ncq_host_sva u_sva(.*);

// ### verif/ncq_host_tb.sv
// Bench: fixed op sequence with random addresses against the flash model, address cycles checked.
module ncq_host_tb;
	import ncq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, resetn = 0, op_valid = 0, wr_valid = 0, rd_ready = 0;
	logic op_ready, op_done, cs_n, cl, al, we_n, re_n, oe, rb;
	logic [7:0] wr_data = 0, d_o, q, rd_data;
	logic rd_valid;
	int rd_cnt = 0;
	logic [11:0] op_col = 0;
	logic [5:0] op_page = 0;
	logic [9:0] op_block = 0;
	ncq_op_t op_code = NCQ_OP_RESET;
	int error_cnt = 0, comparisons = 0, k;
	ncq_host dut(.clk, .resetn, .ce(1'b1), .op_valid, .op_ready, .op_code, .op_col,
		.op_page, .op_block, .op_len(12'h004), .op_done, .op_rejected(), .wr_valid,
		.wr_ready(), .wr_data, .rd_valid, .rd_ready, .rd_data, .chip_sel_n(cs_n),
		.cmd_latch(cl), .addr_latch(al), .write_strobe_n(we_n), .read_strobe_n(re_n),
		.write_prot_n(), .byte_port_o(d_o), .byte_port_oe(oe),
		.byte_port_i(oe ? d_o : q), .ready_busy(rb));
	ncq_flash_model fm(.clk, .cs_n, .cl, .al, .we_n, .re_n, .d(d_o), .rb, .q);
	task automatic chk(input logic [7:0] g, e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic finish_test;
		if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	function automatic logic [7:0] exp_a(input int n, i, input logic [31:0] v);
		return 8'(v >> (n == 2 ? 16 + 8 * i : 8 * i));
	endfunction : exp_a
	task automatic run(input ncq_op_t c, input int n, input logic [11:0] col);
		@(posedge clk);
		op_code <= c;
		op_col <= col;
		op_page <= 6'($urandom);
		op_block <= 10'($urandom);
		op_valid <= 1'b1;
		k = 0;
		do @(negedge clk); while (op_ready !== 1'b1 && ++k < 4000);
		@(posedge clk);
		op_valid <= 1'b0;
		k = 0;
		do @(negedge clk); while (op_done !== 1'b1 && ++k < 20000);
		chk({7'h0, op_done}, 8'h01);
		for (int i = 0; i < n; i++) chk(fm.a[i], exp_a(n, i, {op_block, op_page, 4'h0, op_col}));
		if (c == NCQ_OP_PROG) chk(8'(fm.dn), 8'h04);
	endtask : run
	// Each page read returns four fresh bytes counted from one
	always @(posedge clk) if (resetn && rd_valid === 1'b1 && rd_ready === 1'b1) begin
		chk(rd_data, 8'(rd_cnt % 4 + 1));
		rd_cnt++;
	end
	initial forever #20 clk = ~clk;
	initial begin
		#2000000;
		error_cnt++;
		finish_test();
	end
	always @(posedge clk) begin
		wr_data <= 8'($urandom);
		rd_ready <= 1'($urandom);
	end
	initial begin
		void'($urandom(7));
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		wr_valid <= 1'b1;
		run(NCQ_OP_RESET, 0, 12'h000);
		run(NCQ_OP_READ, 4, 12'h800);
		run(NCQ_OP_PROG, 4, 12'h83F);
		repeat (6) begin
			run(NCQ_OP_READ, 4, 12'($urandom_range(2111)));
			run(NCQ_OP_PROG, 4, 12'($urandom_range(2111)));
			run(NCQ_OP_ERASE, 2, 12'h000);
		end
		repeat (40) @(posedge clk);
		chk(8'(rd_cnt), 8'h1C);
		finish_test();
	end
endmodule : ncq_host_tb
